// file: core/pct_pkg.sv
// Purpose: constants for the pin continuity test block
// Assumes: 50 MHz clk
// Notes: timing counts derived from printed times
package pct_pkg;
   localparam int PCT_CLK_PERIOD_NS = 20;
   localparam int PCT_ENABLE_NS = 200;
   localparam int PCT_VALID_NS = 200;
   // least time rounds up, longest time rounds down
   localparam int PCT_ENABLE_CYC = (PCT_ENABLE_NS + PCT_CLK_PERIOD_NS - 1) / PCT_CLK_PERIOD_NS;
   localparam int PCT_VALID_CYC = PCT_VALID_NS / PCT_CLK_PERIOD_NS;
   localparam int PCT_CNT_W = 4;
   localparam int PCT_NUM_MINTERM = 10;
   localparam int PCT_NUM_DQ = 16;
   localparam int PCT_NUM_STROBE = 3;
   localparam logic [PCT_CNT_W-1:0] PCT_CNT_RESET = 4'h0;
   localparam logic [PCT_NUM_DQ-1:0] PCT_DQ_RESET = 16'h0000;
   localparam logic [PCT_NUM_STROBE-1:0] PCT_STROBE_RESET = 3'h0;
   localparam logic PCT_DENSITY_X16 = 1'b1;
endpackage : pct_pkg

// file: core/pct_continuity.sv
// Purpose: x16 parallel pin continuity test logic
// Assumes: pins sampled by two flip-flops on clk; 50 MHz
// Notes: outputs are registered; latency stays inside the valid time
`timescale 1ns/10ps
`default_nettype none
module pct_continuity
   import pct_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic test_enable_pin,
   input wire logic cs_n,
   input wire logic [1:0] ba,
   input wire logic [1:0] bg,
   input wire logic [17:0] addr,
   input wire logic reset_n_pin,
   input wire logic cke,
   input wire logic act_n,
   input wire logic odt,
   input wire logic ck_t,
   input wire logic ck_c,
   input wire logic ldm_n,
   input wire logic udm_n,
   input wire logic par,
   input wire logic alert_n_in,
   output logic [PCT_NUM_DQ-1:0] dq_out,
   output logic [PCT_NUM_DQ-1:0] dq_oe,
   output logic dqsu_out,
   output logic dqsl_t_out,
   output logic dqsl_c_out,
   output logic dqs_oe,
   output logic pin_continuity_mode,
   output logic odt_disable,
   output logic refresh_hold,
   output logic state_invalid
);
   localparam int IN_W = 34;
   // the synchroniser and the mode flop use three of the enable cycles
   localparam logic [PCT_CNT_W-1:0] ENTRY_LAST = PCT_CNT_W'(PCT_ENABLE_CYC - 3);
   logic [IN_W-1:0] raw;
   logic [IN_W-1:0] sync1;
   logic [IN_W-1:0] sync2;
   logic [PCT_CNT_W-1:0] entry_cnt;
   logic [PCT_NUM_MINTERM-1:0] mt;
   logic [PCT_NUM_DQ-1:0] next_dq;
   logic [PCT_NUM_STROBE-1:0] next_strobe;
   logic ten_s;
   logic cs_s;
   logic par_s;
   logic alert_s;
   logic cke_s;
   logic act_s;
   logic odt_s;
   logic ckt_s;
   logic ckc_s;
   logic ldm_s;
   logic udm_s;
   logic rst_s;
   logic [1:0] ba_s;
   logic [1:0] bg_s;
   logic [17:0] a_s;
   logic active;

   assign raw = {test_enable_pin,
                 cs_n,
                 ba,
                 bg,
                 addr,
                 reset_n_pin,
                 cke,
                 act_n,
                 odt,
                 ck_t,
                 ck_c,
                 ldm_n,
                 udm_n,
                 par,
                 alert_n_in};
   assign {ten_s, cs_s, ba_s, bg_s, a_s, rst_s, cke_s, act_s, odt_s,
           ckt_s, ckc_s, ldm_s, udm_s, par_s, alert_s} = sync2;

   // two stage synchroniser on every pin
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   // entry counter; saturates at the last count while enable stays high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         entry_cnt <= PCT_CNT_RESET;
      end else if (!ten_s) begin
         entry_cnt <= PCT_CNT_RESET;
      end else if (entry_cnt < ENTRY_LAST) begin
         entry_cnt <= entry_cnt + 4'h1;
      end
   end

   // mode reported once the enable delay has elapsed
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_continuity_mode <= 1'b0;
      end else if (!ten_s) begin
         pin_continuity_mode <= 1'b0;
      end else if (entry_cnt >= ENTRY_LAST) begin
         pin_continuity_mode <= 1'b1;
      end
   end

   // test logic runs as soon as enable is seen; clock pins are data only
   assign active = ten_s;

   // ten xor terms over the synchronised test inputs
   always_comb begin
      mt[0] = a_s[1] ^ a_s[6] ^ par_s;
      mt[1] = a_s[8] ^ alert_s ^ a_s[9];
      mt[2] = a_s[2] ^ a_s[5] ^ a_s[15];
      mt[3] = a_s[0] ^ a_s[7] ^ a_s[11];
      mt[4] = ckc_s ^ odt_s ^ a_s[15];
      mt[5] = cke_s ^ a_s[16] ^ a_s[10];
      mt[6] = act_s ^ a_s[4] ^ ba_s[1];
      // x16 wiring: the upper mask takes the place of the second group bit
      mt[7] = (PCT_DENSITY_X16 ? udm_s : bg_s[1]) ^ ldm_s ^ ckt_s;
      mt[8] = a_s[14] ^ a_s[12] ^ ba_s[0];
      mt[9] = bg_s[0] ^ a_s[3] ^ (rst_s & ten_s);
   end

   // each even bit carries a term and the odd bit above it the inverse
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_pair
         assign next_dq[2*g] = mt[g];
         assign next_dq[2*g+1] = ~mt[g];
      end
   endgenerate
   // the upper data bits do not follow the simple pairing
   assign next_dq[12] = mt[6];
   assign next_dq[13] = mt[7];
   assign next_dq[14] = mt[8];
   assign next_dq[15] = ~mt[8];
   // {dqsu, dqsl_t, dqsl_c}
   assign next_strobe = {~mt[9], mt[9], ~mt[9]};

   // data outputs fall back to zero while the synchronised enable is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dq_out <= PCT_DQ_RESET;
      end else begin
         dq_out <= active ? next_dq : PCT_DQ_RESET;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {dqsu_out, dqsl_t_out, dqsl_c_out} <= PCT_STROBE_RESET;
      end else begin
         {dqsu_out, dqsl_t_out, dqsl_c_out} <= active ? next_strobe : PCT_STROBE_RESET;
      end
   end

   // drivers enabled only while selected and the synchronised enable is high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dq_oe <= '0;
      end else begin
         dq_oe <= {PCT_NUM_DQ{active & ~cs_s}};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dqs_oe <= 1'b0;
      end else begin
         dqs_oe <= active & ~cs_s;
      end
   end

   // termination forced off while the test logic runs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         odt_disable <= 1'b0;
      end else begin
         odt_disable <= active;
      end
   end

   // array refresh held off while the test logic runs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refresh_hold <= 1'b0;
      end else begin
         refresh_hold <= active;
      end
   end

   // sticky until device reset: contents untrusted after any test entry
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_invalid <= 1'b0;
      end else if (active) begin
         state_invalid <= 1'b1;
      end
   end
endmodule : pct_continuity
`default_nettype wire

// file: bench/pct_agent.sv
// Purpose: model of the board test agent
// Assumes: agent owns the reset pin
// Notes: test patterns come from the bench tasks
`timescale 1ns/10ps
`default_nettype none
module pct_agent (
   output logic reset_n_pin
);
   assign reset_n_pin = 1'b1;
endmodule : pct_agent
`default_nettype wire

// file: bench/pct_continuity_sva.sv
// Purpose: checker for pct_continuity
// Assumes: outputs 3 edges after inputs
// Notes: cause bits piped beside the design
`timescale 1ns/10ps
`default_nettype none
module pct_continuity_sva
   import pct_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic test_enable_pin,
   input wire logic cs_n,
   input wire logic par,
   input wire logic [17:0] addr,
   input wire logic [PCT_NUM_DQ-1:0] dq_out,
   input wire logic [PCT_NUM_DQ-1:0] dq_oe,
   input wire logic dqsu_out,
   input wire logic dqsl_t_out,
   input wire logic dqsl_c_out,
   input wire logic dqs_oe,
   input wire logic pin_continuity_mode,
   input wire logic odt_disable,
   input wire logic refresh_hold,
   input wire logic state_invalid
);
   logic [2:0] p0, p1, p2;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) {p2, p1, p0} <= 9'h0;
      else {p2, p1, p0} <= {p1, p0, test_enable_pin & ~cs_n, test_enable_pin,
         test_enable_pin & (addr[1] ^ addr[6] ^ par)};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_MT0: assert property (dq_out[0] == p2[0]) else $error("dq0 wrong");
   AST_PAIR: assert property (p2[1] |-> dq_out[1] != dq_out[0] && dq_out[15] != dq_out[14])
      else $error("pair wrong");
   AST_STROBE: assert property (p2[1] |-> dqsl_c_out != dqsl_t_out && dqsu_out == dqsl_c_out)
      else $error("strobe wrong");
   AST_OE: assert property ({dq_oe, dqs_oe} == {17{p2[2]}}) else $error("oe wrong");
   AST_ODT: assert property (odt_disable == p2[1]) else $error("odt wrong");
   AST_REFRESH: assert property (refresh_hold == p2[1])
      else $error("refresh wrong");
   AST_ENTRY: assert property ($rose(test_enable_pin) ##1 test_enable_pin[*8] |=>
      ##[0:2] pin_continuity_mode) else $error("entry late");
   AST_STICKY: assert property ($rose(odt_disable) |-> state_invalid[*4])
      else $error("invalid wrong");
   cover property ($rose(pin_continuity_mode));
   cover property (odt_disable && dqs_oe);
   cover property (odt_disable && !dqs_oe);
endmodule : pct_continuity_sva
bind pct_continuity pct_continuity_sva i_pct_continuity_sva (
   .clk(clk),
   .rstn(rstn),
   .test_enable_pin(test_enable_pin),
   .cs_n(cs_n),
   .par(par),
   .addr(addr),
   .dq_out(dq_out),
   .dq_oe(dq_oe),
   .dqsu_out(dqsu_out),
   .dqsl_t_out(dqsl_t_out),
   .dqsl_c_out(dqsl_c_out),
   .dqs_oe(dqs_oe),
   .pin_continuity_mode(pin_continuity_mode),
   .odt_disable(odt_disable),
   .refresh_hold(refresh_hold),
   .state_invalid(state_invalid)
);
`default_nettype wire

// file: bench/pct_continuity_tb.sv
// Purpose: bench for pct_continuity
// Assumes: 20 ns clock, outputs read once the valid time has passed
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
module pct_continuity_tb;
   import pct_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, test_enable_pin = 1'b0, cs_n = 1'b1;
   logic [30:0] pin = 31'h0;
   wire [1:0] ba, bg;
   wire [17:0] addr;
   wire cke, act_n, odt, ck_t, ck_c, ldm_n, udm_n, par, alert_n_in, reset_n_pin;
   logic [15:0] dq_out, dq_oe;
   logic dqsu_out, dqsl_t_out, dqsl_c_out, dqs_oe, pin_continuity_mode;
   logic odt_disable, refresh_hold, state_invalid;
   int n_mismatch = 0, samples_checked = 0;
   assign {alert_n_in, par, udm_n, ldm_n, ck_c, ck_t, odt, act_n, cke, addr, bg, ba} = pin;
   always #10 clk = ~clk;
   pct_agent i_pct_agent (.reset_n_pin(reset_n_pin));
   pct_continuity i_pct_continuity (
      .clk(clk),
      .rstn(rstn),
      .test_enable_pin(test_enable_pin),
      .cs_n(cs_n),
      .ba(ba),
      .bg(bg),
      .addr(addr),
      .reset_n_pin(reset_n_pin),
      .cke(cke),
      .act_n(act_n),
      .odt(odt),
      .ck_t(ck_t),
      .ck_c(ck_c),
      .ldm_n(ldm_n),
      .udm_n(udm_n),
      .par(par),
      .alert_n_in(alert_n_in),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .dqsu_out(dqsu_out),
      .dqsl_t_out(dqsl_t_out),
      .dqsl_c_out(dqsl_c_out),
      .dqs_oe(dqs_oe),
      .pin_continuity_mode(pin_continuity_mode),
      .odt_disable(odt_disable),
      .refresh_hold(refresh_hold),
      .state_invalid(state_invalid)
   );
   task automatic cmp(logic [37:0] g, logic [37:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic apply(logic [30:0] p, logic t, logic c);
      logic [9:0] m;
      logic [20:0] e;
      logic [37:0] g;
      pin = p;
      test_enable_pin = t;
      cs_n = c;
      repeat (PCT_VALID_CYC) @(posedge clk);
      #1;
      m = {p[2]^p[7]^t, p[18]^p[16]^p[0], p[28]^p[27]^p[25], p[23]^p[8]^p[1], p[22]^p[20]^p[14],
         p[26]^p[24]^p[19], p[4]^p[11]^p[15], p[6]^p[9]^p[19], p[12]^p[30]^p[13], p[5]^p[10]^p[29]};
      e = t ? {~c, 1'b1, ~m[9], m[9], ~m[9], ~m[8], m[8], m[7:6], ~m[5], m[5], ~m[4], m[4],
         ~m[3], m[3], ~m[2], m[2], ~m[1], m[1], ~m[0], m[0]} : 21'h0;
      g = {refresh_hold, dq_oe, dqs_oe, odt_disable, dqsu_out, dqsl_t_out, dqsl_c_out, dq_out};
      cmp(g, {e[19], {16{e[20]}}, e});
   endtask : apply
   task automatic entry;
      cmp({36'h0, state_invalid, pin_continuity_mode}, 38'h0);
      test_enable_pin = 1'b1;
      cs_n = 1'b0;
      repeat (PCT_ENABLE_CYC) @(posedge clk);
      #1;
      cmp({37'h0, pin_continuity_mode}, 38'h1);
   endtask : entry
   task automatic walk;
      apply(31'h0, 1'b1, 1'b0);
      for (int i = 0; i < 31; i++) apply(31'h1 << i, 1'b1, 1'b0);
      apply(31'h7FFFFFFF, 1'b1, 1'b0);
   endtask : walk
   task automatic tristate;
      apply(31'h2A5A5A5A, 1'b1, 1'b1);
      apply(31'h2A5A5A5A, 1'b1, 1'b0);
   endtask : tristate
   task automatic bypass;
      apply(31'h7FFFFFFF, 1'b0, 1'b0);
      cmp({36'h0, state_invalid, pin_continuity_mode}, 38'h2);
      rstn = 1'b0;
      @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1;
      cmp({37'h0, state_invalid}, 38'h0);
   endtask : bypass
   task automatic results;
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      repeat (12) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1;
      entry();
      walk();
      tristate();
      bypass();
      results();
   end
   initial begin
      #20000;
      n_mismatch++;
      results();
   end
endmodule : pct_continuity_tb
`default_nettype wire
